/* File: cam_pkg.sv */
package cam_pkg;
  // geometry of the content-addressable store
  localparam int CAM_WORDS  = 32;
  localparam int CAM_WIDTH  = 32;
  localparam int CAM_ADDR_W = 5;
  localparam int CAM_LINES  = 16;
  // reset values of the store and of the care masks
  localparam logic [31:0] CAM_DATA_RST = 32'h0000_0000;
  localparam logic [31:0] CAM_CARE_ALL = 32'hffff_ffff;
  localparam logic [31:0] CAM_CARE_RST = 32'hffff_ffff;
  // unencoded output halves
  localparam logic        CAM_HALF_LO  = 1'h0;
  localparam logic        CAM_HALF_HI  = 1'h1;
  // run-time write sequencer
  typedef enum logic [1:0] {st_idle, st_data, st_mask} cam_wr_state_t;
endpackage

/* File: cam_mem_if.sv */
`timescale 1ns/10ps
interface cam_mem_if;
  import cam_pkg::*;
  logic                  we_data;
  logic                  we_care;
  logic [CAM_ADDR_W-1:0] waddr;
  logic [CAM_WIDTH-1:0]  wdata;
  logic [CAM_WIDTH-1:0]  wcare;
  logic                  srch_stb;
  logic [CAM_WIDTH-1:0]  srch_data;
  logic [CAM_WORDS-1:0]  match;
  logic                  match_vld;
  modport ctrl (output we_data, we_care, waddr, wdata, wcare, srch_stb, srch_data,
                input match, match_vld);
  modport mem  (input we_data, we_care, waddr, wdata, wcare, srch_stb, srch_data,
                output match, match_vld);
endinterface

/* File: cam_store.sv */
`timescale 1ns/10ps
module cam_store
  import cam_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // write and search port
  cam_mem_if.mem   mif
);
  logic [CAM_WIDTH-1:0] data_ff [CAM_WORDS];
  logic [CAM_WIDTH-1:0] care_ff [CAM_WORDS];
  logic [CAM_WORDS-1:0] vld_ff;
  logic [CAM_WORDS-1:0] hit_w;
  logic [CAM_WORDS-1:0] match_ff;
  logic                 match_vld_ff;

  // one stored word, its care mask and a written flag per entry
  for (genvar g = 0; g < CAM_WORDS; g++) begin : g_word
    wire sel_w = (mif.waddr == CAM_ADDR_W'(g));
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        data_ff[g] <= CAM_DATA_RST;
        care_ff[g] <= CAM_CARE_RST;
        vld_ff[g]  <= 1'h0;
      end else begin
        if (mif.we_data && sel_w) begin
          data_ff[g] <= mif.wdata;
          vld_ff[g]  <= 1'h1;
        end
        if (mif.we_care && sel_w) begin
          care_ff[g] <= mif.wcare;
        end
      end
    end
    // masked compare, cleared care bits never block a hit
    assign hit_w[g] = vld_ff[g] && (((data_ff[g] ^ mif.srch_data) & care_ff[g]) == '0);
  end

  // all 32 words compared at once, result registered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      match_ff     <= '0;
      match_vld_ff <= 1'h0;
    end else begin
      match_vld_ff <= mif.srch_stb;
      if (mif.srch_stb) begin
        match_ff <= hit_w;
      end
    end
  end
  assign mif.match     = match_ff;
  assign mif.match_vld = match_vld_ff;

  a_full_care_miss: assert property (@(posedge clk) disable iff (!reset_n)
    (mif.we_data && mif.we_care && mif.wcare == CAM_CARE_ALL) ##1
    (mif.srch_stb && mif.srch_data != $past(mif.wdata) && !mif.we_data && !mif.we_care)
    |=> !match_ff[$past(mif.waddr, 2)])
    else $error("full-care word matched different search data");

  a_masked_bits_hit: assert property (@(posedge clk) disable iff (!reset_n)
    (mif.we_data && mif.we_care) ##1
    (mif.srch_stb && !mif.we_data && !mif.we_care &&
     ((mif.srch_data ^ $past(mif.wdata)) & $past(mif.wcare)) == '0)
    |=> match_ff[$past(mif.waddr, 2)])
    else $error("search equal on cared bits did not match");
endmodule

/* File: cam_top.sv */
`timescale 1ns/10ps
module cam_top
  import cam_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // configuration-time preload
  input  wire logic                  cfg_load,
  input  wire logic [CAM_ADDR_W-1:0] cfg_addr,
  input  wire logic [CAM_WIDTH-1:0]  cfg_data,
  input  wire logic [CAM_WIDTH-1:0]  cfg_care,
  // run-time write
  input  wire logic                  wr_req,
  input  wire logic [CAM_ADDR_W-1:0] wr_addr,
  input  wire logic [CAM_WIDTH-1:0]  wr_data,
  input  wire logic [CAM_WIDTH-1:0]  wr_care,
  input  wire logic                  wr_use_mask,
  output logic                       wr_busy_ff,
  output logic                       wr_done_ff,
  // search request
  input  wire logic                  srch_valid,
  input  wire logic [CAM_WIDTH-1:0]  srch_data,
  input  wire logic                  enc_mode,
  output logic                       srch_gap_ff,
  // encoded result
  output logic                       enc_valid_ff,
  output logic                       enc_hit_ff,
  output logic [CAM_ADDR_W-1:0]      enc_addr_ff,
  // unencoded result
  output logic                       vec_valid_ff,
  output logic                       vec_half_ff,
  output logic [CAM_LINES-1:0]       vec_lines_ff
);
  cam_mem_if mif ();

  cam_wr_state_t         state_ff;
  cam_wr_state_t         nxt_state;
  logic [CAM_ADDR_W-1:0] addr_ff;
  logic [CAM_WIDTH-1:0]  data_ff;
  logic [CAM_WIDTH-1:0]  care_ff;
  logic                  mask_ff;
  logic                  mode_p1_ff;
  logic [CAM_LINES-1:0]  upper_ff;
  logic [CAM_ADDR_W-1:0] enc_w;

  cam_store u_store (
    .clk     (clk),
    .reset_n (reset_n),
    .mif     (mif)
  );

  // write acceptance and store write strobes; preload wins and stalls the sequencer
  wire wr_take  = (state_ff == st_idle) && wr_req && !wr_done_ff && !cfg_load;
  wire in_data  = (state_ff == st_data) && !cfg_load;
  wire in_mask  = (state_ff == st_mask) && !cfg_load;
  assign mif.we_data = cfg_load || in_data;
  assign mif.we_care = cfg_load || (in_data && !mask_ff) || in_mask;
  assign mif.waddr   = cfg_load ? cfg_addr : addr_ff;
  assign mif.wdata   = cfg_load ? cfg_data : data_ff;
  assign mif.wcare   = cfg_load ? cfg_care : (in_mask ? care_ff : CAM_CARE_ALL);

  // write sequencer: data cycle, then a mask cycle when don't-care bits are used
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_idle: if (wr_take) nxt_state = st_data;
      st_data: if (!cfg_load) nxt_state = mask_ff ? st_mask : st_idle;
      st_mask: if (!cfg_load) nxt_state = st_idle;
      default: nxt_state = st_idle;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff   <= st_idle;
      addr_ff    <= '0;
      data_ff    <= CAM_DATA_RST;
      care_ff    <= CAM_CARE_RST;
      mask_ff    <= 1'h0;
      wr_busy_ff <= 1'h0;
      wr_done_ff <= 1'h0;
    end else begin
      state_ff   <= nxt_state;
      wr_busy_ff <= (nxt_state != st_idle);
      wr_done_ff <= (nxt_state == st_idle) && (state_ff != st_idle);
      if (wr_take) begin
        addr_ff <= wr_addr;
        data_ff <= wr_data;
        care_ff <= wr_care;
        mask_ff <= wr_use_mask;
      end
    end
  end

  // search intake; unencoded results need two output cycles, so one idle cycle follows
  wire srch_take = srch_valid && !srch_gap_ff;
  assign mif.srch_stb  = srch_take;
  assign mif.srch_data = srch_data;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      srch_gap_ff <= 1'h0;
      mode_p1_ff  <= 1'h0;
    end else begin
      srch_gap_ff <= srch_take && !enc_mode;
      if (srch_take) mode_p1_ff <= enc_mode;
    end
  end

  // lowest matching index wins the encoder
  always_comb begin
    enc_w = '0;
    for (int i = CAM_WORDS - 1; i >= 0; i--) begin
      if (mif.match[i]) enc_w = CAM_ADDR_W'(i);
    end
  end

  // encoded result with hit flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enc_valid_ff <= 1'h0;
      enc_hit_ff   <= 1'h0;
      enc_addr_ff  <= '0;
    end else begin
      enc_valid_ff <= mif.match_vld && mode_p1_ff;
      if (mif.match_vld && mode_p1_ff) begin
        enc_hit_ff  <= |mif.match;
        enc_addr_ff <= enc_w;
      end
    end
  end

  // unencoded result: low half first, high half on the next cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vec_valid_ff <= 1'h0;
      vec_half_ff  <= CAM_HALF_LO;
      vec_lines_ff <= '0;
      upper_ff     <= '0;
    end else if (mif.match_vld && !mode_p1_ff) begin
      vec_valid_ff <= 1'h1;
      vec_half_ff  <= CAM_HALF_LO;
      vec_lines_ff <= mif.match[CAM_LINES-1:0];
      upper_ff     <= mif.match[CAM_WORDS-1:CAM_LINES];
    end else if (vec_valid_ff && vec_half_ff == CAM_HALF_LO) begin
      vec_half_ff  <= CAM_HALF_HI;
      vec_lines_ff <= upper_ff;
    end else begin
      vec_valid_ff <= 1'h0;
      vec_half_ff  <= CAM_HALF_LO;
      vec_lines_ff <= '0;
    end
  end

  a_enc_onehot_addr: assert property (@(posedge clk) disable iff (!reset_n)
    (mif.match_vld && mode_p1_ff && $onehot(mif.match))
    |=> enc_valid_ff && enc_hit_ff && ((32'h1 << enc_addr_ff) == $past(mif.match)))
    else $error("encoded address does not point at the matching word");

  a_enc_no_hit: assert property (@(posedge clk) disable iff (!reset_n)
    (mif.match_vld && mode_p1_ff && mif.match == '0) |=> enc_valid_ff && !enc_hit_ff)
    else $error("hit flag raised with no matching word");

  a_vec_two_halves: assert property (@(posedge clk) disable iff (!reset_n)
    (mif.match_vld && !mode_p1_ff)
    |=> (vec_valid_ff && !vec_half_ff) ##1 (vec_valid_ff && vec_half_ff) ##1 !vec_half_ff)
    else $error("unencoded result not shown as two halves");

  a_vec_all_flags: assert property (@(posedge clk) disable iff (!reset_n)
    (mif.match_vld && !mode_p1_ff)
    |=> vec_lines_ff == $past(mif.match[15:0]) ##1 vec_lines_ff == $past(mif.match[31:16], 2))
    else $error("unencoded lines differ from the match flags");

  // preload and write sequencer checks
  a_cfg_preload: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_load ##1 (srch_take && !cfg_load && !mif.we_data &&
     ((srch_data ^ $past(cfg_data)) & $past(cfg_care)) == '0)
    |=> mif.match[$past(cfg_addr, 2)])
    else $error("preloaded word did not match the next search");

  a_wr_two_cycles: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_take && !wr_use_mask) ##1 !cfg_load |-> wr_busy_ff ##1 (wr_done_ff && !wr_busy_ff))
    else $error("plain write did not finish in two cycles");

  a_wr_three_cycles: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_take && wr_use_mask) ##1 !cfg_load [*2] |-> ##1 (wr_done_ff && !wr_busy_ff))
    else $error("masked write did not finish in three cycles");

  a_wr_take_busy: assert property (@(posedge clk) disable iff (!reset_n)
    wr_take |=> wr_busy_ff && !wr_done_ff)
    else $error("accepted write did not raise busy");

  a_wr_preload_stall: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff != st_idle && cfg_load) |=> wr_busy_ff && !wr_done_ff)
    else $error("write did not stall under a preload");

  a_done_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
    wr_done_ff |=> !wr_done_ff)
    else $error("write done lasted more than one cycle");

  // search intake and result hold checks
  a_srch_gap_drop: assert property (@(posedge clk) disable iff (!reset_n)
    srch_gap_ff |=> !mif.match_vld)
    else $error("search taken in the gap after an unencoded search");

  a_enc_hit_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !(mif.match_vld && mode_p1_ff) |=> $stable(enc_hit_ff) && $stable(enc_addr_ff))
    else $error("encoded result changed without a new search");

  a_enc_pulse_once: assert property (@(posedge clk) disable iff (!reset_n)
    (enc_valid_ff && !(mif.match_vld && mode_p1_ff)) |=> !enc_valid_ff)
    else $error("encoded valid stood longer than one cycle");
endmodule

/* File: cam_fabric_model.sv */
`timescale 1ns/10ps
// fabric-side writer: drives run-time writes and holds each until the done pulse
module cam_fabric_model
  import cam_pkg::*;
(
  // clock
  input  wire logic                  clk,
  // write port towards the store
  output logic                       wr_req,
  output logic [CAM_ADDR_W-1:0]      wr_addr,
  output logic [CAM_WIDTH-1:0]       wr_data,
  output logic [CAM_WIDTH-1:0]       wr_care,
  output logic                       wr_use_mask,
  // write status from the store
  input  wire logic                  wr_busy_ff,
  input  wire logic                  wr_done_ff
);
  // idle until the first write
  initial begin
    wr_req      = 1'h0;
    wr_addr     = 5'h00;
    wr_data     = 32'h0000_0000;
    wr_care     = 32'h0000_0000;
    wr_use_mask = 1'h0;
  end

  // one write from a falling edge; n = cycles to done, nb = busy cycles
  task automatic write(input logic [4:0] a, input logic [31:0] d, input logic [31:0] c,
                       input logic m, output int n, output int nb);
    n           = 0;
    nb          = 0;
    wr_req      = 1'h1;
    wr_addr     = a;
    wr_data     = d;
    wr_care     = c;
    wr_use_mask = m;
    // request and fields held until done is seen, bounded wait
    do begin
      @(negedge clk);
      n++;
      if (wr_busy_ff === 1'h1) nb++;
    end while (wr_done_ff !== 1'h1 && n < 20);
    // release in the done cycle; released fields carry no stale value
    wr_req      = 1'h0;
    wr_addr     = ~a;
    wr_data     = ~d;
    wr_care     = ~c;
    wr_use_mask = ~m;
    // let the done cycle pass, a request raised in it would be refused
    @(negedge clk);
  endtask
endmodule

/* File: tb_content_addressable_memory.sv */
`timescale 1ns/10ps
module tb_content_addressable_memory
  import cam_pkg::*;
;
  typedef struct {
    logic [31:0] d;
    logic        enc;
    logic        hit;
    logic [4:0]  a;
    logic [31:0] v;
  } cam_row_t;
  logic                  clk = 1'h0;
  logic                  reset_n, cfg_load, srch_valid, enc_mode, wr_req, wr_use_mask;
  logic                  wr_busy_ff, wr_done_ff, srch_gap_ff, enc_valid_ff, enc_hit_ff;
  logic                  vec_valid_ff, vec_half_ff;
  logic [CAM_ADDR_W-1:0] cfg_addr, wr_addr, enc_addr_ff;
  logic [CAM_WIDTH-1:0]  cfg_data, cfg_care, wr_data, wr_care, srch_data;
  logic [CAM_LINES-1:0]  vec_lines_ff;
  int                    errors = 0, n_compared = 0, cycles = 0, n, nb;
  // ordinary searches: data, encoded, hit, address, match vector
  cam_row_t rows [8] = '{'{32'h1234_5678, 1'h0, 1'h0, 5'h00, 32'h0200_1000},
    '{32'hab12_34cd, 1'h1, 1'h1, 5'h03, 32'h0}, '{32'hac00_00cd, 1'h1, 1'h0, 5'h00, 32'h0},
    '{32'hcafe_0001, 1'h1, 1'h1, 5'h14, 32'h0}, '{32'h5a5a_ff77, 1'h1, 1'h1, 5'h07, 32'h0},
    '{32'h5a5a_ff77, 1'h0, 1'h0, 5'h00, 32'h80}, '{32'h0000_0000, 1'h1, 1'h0, 5'h00, 32'h0},
    '{32'hcafe_0001, 1'h0, 1'h0, 5'h00, 32'h0010_0000}};

  cam_top i_cam_top (.clk, .reset_n, .cfg_load, .cfg_addr, .cfg_data, .cfg_care, .wr_req,
    .wr_addr, .wr_data, .wr_care, .wr_use_mask, .wr_busy_ff, .wr_done_ff, .srch_valid,
    .srch_data, .enc_mode, .srch_gap_ff, .enc_valid_ff, .enc_hit_ff, .enc_addr_ff,
    .vec_valid_ff, .vec_half_ff, .vec_lines_ff);
  cam_fabric_model i_cam_fabric_model (.clk, .wr_req, .wr_addr, .wr_data, .wr_care,
    .wr_use_mask, .wr_busy_ff, .wr_done_ff);

  // 8 ns clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // preload one word; caller lowers the strobe
  task automatic preload(input logic [4:0] a, input logic [31:0] d, input logic [31:0] c);
    cfg_load = 1'h1;
    cfg_addr = a;
    cfg_data = d;
    cfg_care = c;
    @(negedge clk);
  endtask

  // one search from a falling edge, results checked cycle by cycle
  task automatic srch(input cam_row_t r);
    srch_valid = 1'h1;
    srch_data  = r.d;
    enc_mode   = r.enc;
    @(negedge clk);
    srch_valid = 1'h0;
    srch_data  = ~r.d;
    if (!r.enc) chk("gap", srch_gap_ff, 1);
    @(negedge clk);
    if (r.enc) begin
      chk("enc_valid", enc_valid_ff, 1);
      chk("enc_hit", enc_hit_ff, r.hit);
      if (r.hit) chk("enc_addr", enc_addr_ff, r.a);
    end else begin
      chk("vec_half0", {vec_valid_ff, vec_half_ff}, 2);
      chk("vec_lo", vec_lines_ff, r.v[15:0]);
    end
    @(negedge clk);
    if (r.enc) begin
      chk("enc_pulse", enc_valid_ff, 0);
    end else begin
      chk("vec_half1", {vec_valid_ff, vec_half_ff}, 3);
      chk("vec_hi", vec_lines_ff, r.v[31:16]);
    end
    @(negedge clk);
    chk("vec_idle", {vec_valid_ff, vec_lines_ff}, 0);
  endtask

  initial begin
    {reset_n, cfg_load, srch_valid, enc_mode, cfg_addr} = '0;
    {cfg_data, cfg_care, srch_data} = '0;
    repeat (8) @(negedge clk);
    chk("reset_wr", {wr_busy_ff, wr_done_ff, srch_gap_ff}, 0);
    chk("reset_res", {enc_valid_ff, vec_valid_ff}, 0);
    reset_n = 1'h1;
    @(negedge clk);
    srch('{32'h0, 1'h1, 1'h0, 5'h00, 32'h0});
    $display("test reset done");
    // preload a plain and a masked word, then run-time writes
    preload(5'h0c, 32'h1234_5678, 32'hffff_ffff);
    preload(5'h03, 32'hab00_00cd, 32'hff00_00ff);
    cfg_load = 1'h0;
    i_cam_fabric_model.write(5'h14, 32'hcafe_0001, 32'h0, 1'h0, n, nb);
    chk("plain_cycles", {n[7:0], nb[7:0]}, 16'h0201);
    i_cam_fabric_model.write(5'h07, 32'h5a5a_0000, 32'hffff_0000, 1'h1, n, nb);
    chk("mask_cycles", {n[7:0], nb[7:0]}, 16'h0302);
    // duplicate on purpose, read only through the unencoded lines
    i_cam_fabric_model.write(5'h19, 32'h1234_5678, 32'h0, 1'h0, n, nb);
    chk("dup_cycles", {n[7:0], nb[7:0]}, 16'h0201);
    $display("test writes done");
    foreach (rows[i]) srch(rows[i]);
    $display("test row searches done");
    // preload during a run-time write stalls it by one cycle
    fork
      i_cam_fabric_model.write(5'h1e, 32'h0bad_f00d, 32'h0, 1'h0, n, nb);
      begin
        @(negedge clk);
        preload(5'h1f, 32'h0000_0077, 32'hffff_ffff);
        cfg_load = 1'h0;
      end
    join
    chk("stall_cycles", n[7:0], 8'h03);
    srch('{32'h0000_0077, 1'h1, 1'h1, 5'h1f, 32'h0});
    // back-to-back encoded searches
    srch_valid = 1'h1;
    enc_mode   = 1'h1;
    srch_data  = 32'h0bad_f00d;
    @(negedge clk);
    srch_data = 32'hab00_00cd;
    @(negedge clk);
    srch_valid = 1'h0;
    chk("b2b_first", {enc_valid_ff, enc_hit_ff, enc_addr_ff}, 7'h7e);
    @(negedge clk);
    chk("b2b_second", {enc_valid_ff, enc_hit_ff, enc_addr_ff}, 7'h63);
    // search in the gap cycle after an unencoded search is dropped
    srch_valid = 1'h1;
    enc_mode   = 1'h0;
    @(negedge clk);
    enc_mode = 1'h1;
    @(negedge clk);
    srch_valid = 1'h0;
    @(negedge clk);
    chk("gap_refused", enc_valid_ff, 0);
    // a plain rewrite clears the old mask
    i_cam_fabric_model.write(5'h07, 32'h5a5a_0000, 32'h0, 1'h0, n, nb);
    chk("rewrite_cycles", {n[7:0], nb[7:0]}, 16'h0201);
    srch('{32'h5a5a_ff77, 1'h1, 1'h0, 5'h00, 32'h0});
    // a preload is searched in the very next cycle, full care and masked
    preload(5'h1d, 32'h0000_00a5, 32'hffff_ffff);
    cfg_load = 1'h0;
    srch('{32'h0000_00a4, 1'h1, 1'h0, 5'h00, 32'h0});
    preload(5'h1c, 32'h0000_00a6, 32'hffff_fff0);
    cfg_load = 1'h0;
    srch('{32'h0000_00a0, 1'h1, 1'h1, 5'h1c, 32'h0});
    $display("test awkward cases done");
    // reset in mid-run clears every output and the whole store
    reset_n = 1'h0;
    @(negedge clk);
    chk("reset_mid_wr", {wr_busy_ff, wr_done_ff, srch_gap_ff}, 0);
    chk("reset_mid_enc", {enc_valid_ff, enc_hit_ff, enc_addr_ff}, 0);
    chk("reset_mid_vec", {vec_valid_ff, vec_half_ff, vec_lines_ff}, 0);
    reset_n = 1'h1;
    @(negedge clk);
    srch('{32'h0000_00a0, 1'h1, 1'h0, 5'h00, 32'h0});
    srch('{32'h1234_5678, 1'h0, 1'h0, 5'h00, 32'h0});
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
